// file: design/rcs_completion_stream_out.v
// Completion packet output stream: buffering, beat framing, keep, sideband
// Notes on behaviour
// - Sideband describes the current packet; only meaningful while valid is high.
// - Last-beat flag set in each packet's final beat, including single-beat packets.
// - Last-beat flag held low when 256-bit straddling is enabled.
// - Dword keep contiguous from first descriptor dword; only a short final beat is partial.
// - Keep bits 7:4 low on 128-bit bus, 7:2 low on 64-bit bus.
// - Straddle mode keeps all keep bits high; user reads start/end markers instead.
// - Valid high when data is presented and held for the whole packet if it fits in the buffer.
// - A beat transfers only when valid and ready are both high.
// - When ready drops under valid, data, sideband and valid stay unchanged.
// - Byte-valid bits mark payload bytes only, never descriptor bytes, contiguous within each packet.
// - Byte-valid bits 31:16 low on 128-bit bus, 31:8 low on 64-bit.
// - Zero-length read completions still get a byte-valid bit set.
// - Without straddling, first start flag marks first beat; second start flag stays low.
// - Straddle: first start flag marks a packet starting at lane 0.
// - Second start flag: packet at lane 16, only after first packet ended in 0-15.
// - Straddle only: first-end field gives end flag and last-dword offset.
// - Second-end field: end flag, offset 6 or 7, implies first end and second start.
// - Abort flag only in last payload beat on buffer read error; user discards packet.
// - Sideband 74:43 carries odd parity per byte, upper bits low when narrow.
// - Data bits above the configured bus width are held low.
`timescale 1ns/1ps
`default_nettype none
`include "rcs_regs.vh"

module rcs_completion_stream_out #(
  parameter integer DW       = 256,
  parameter integer STRADDLE = 0,
  parameter integer DEPTH    = `RCS_FIFO_DEPTH,
  parameter integer AW       = `RCS_FIFO_AW
) (
  // Clock and reset
  input  wire                  clk_sys_i,
  input  wire                  reset_i,
  // Packet beats from the completion buffer
  input  wire                  src_valid_i,
  output wire                  src_ready_o,
  input  wire [255:0]          src_data_i,
  input  wire [3:0]            src_dword_count_i,
  input  wire [31:0]           src_byte_en_i,
  input  wire                  src_first_i,
  input  wire                  src_last_i,
  input  wire                  src_abort_i,
  input  wire                  src_zero_len_i,
  // Completion output stream
  output reg  [255:0]          completion_out_data_o,
  output reg  [`RCS_SB_W-1:0]  completion_out_sideband_o,
  output reg                   completion_out_last_beat_o,
  output reg  [7:0]            completion_out_dword_keep_o,
  output reg                   completion_out_valid_o,
  input  wire                  completion_out_ready_i
);

  // Straddling exists only on the widest bus; both are fixed at build time
  localparam [0:0] STR = (STRADDLE != 0) && (DW == 256);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_SEND = 2'b10;

  // Width masks
  function [31:0] fit_bytes;
    input [31:0] v;
    begin
      if (DW == 64) begin
        fit_bytes = v & 32'h0000_00ff;
      end else if (DW == 128) begin
        fit_bytes = v & 32'h0000_ffff;
      end else begin
        fit_bytes = v;
      end
    end
  endfunction

  // Strip descriptor bytes and mark zero-length reads
  function [31:0] be_fix;
    input [31:0] be;
    input        first;
    input        second;
    input        zl;
    reg   [31:0] m;
    begin
      m = be;
      if (first) begin
        m = m & 32'hffff_f000;
        if (zl && DW != 64) begin
          m = m | 32'h0000_1000;
        end
      end
      if (second && DW == 64) begin
        m = m & 32'hffff_fff0;
        if (zl) begin
          m = m | 32'h0000_0010;
        end
      end
      be_fix = fit_bytes(m);
    end
  endfunction

  function [7:0] keep_of;
    input [3:0] cnt;
    reg   [7:0] k;
    begin
      k = (8'h01 << cnt) - 8'h01;
      if (DW == 64) begin
        keep_of = k & 8'h03;
      end else if (DW == 128) begin
        keep_of = k & 8'h0f;
      end else begin
        keep_of = k;
      end
    end
  endfunction

  function [255:0] fit_data;
    input [255:0] d;
    begin
      if (DW == 64) begin
        fit_data = {192'h0, d[63:0]};
      end else if (DW == 128) begin
        fit_data = {128'h0, d[127:0]};
      end else begin
        fit_data = d;
      end
    end
  endfunction

  // Buffer
  wire [`RCS_E_W-1:0] push_word = {src_zero_len_i, src_abort_i, src_last_i, src_first_i,
                                   src_dword_count_i, src_byte_en_i, src_data_i};
  wire [`RCS_E_W-1:0] head;
  wire [`RCS_E_W-1:0] nxt;
  wire                head_valid;
  wire                nxt_valid;
  wire                take;
  wire                merge;

  rcs_fifo #(
    .W     (`RCS_E_W),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_fifo (
    .clk_sys_i    (clk_sys_i),
    .reset_i      (reset_i),
    .in_valid_i   (src_valid_i),
    .in_ready_o   (src_ready_o),
    .in_data_i    (push_word),
    .out_valid_o  (head_valid),
    .out_ready_i  (take),
    .out_data_o   (head),
    .out2_valid_o (nxt_valid),
    .out2_data_o  (nxt),
    .out2_take_i  (merge)
  );

  wire [255:0] h_data  = head[`RCS_E_DATA_LO +: 256];
  wire [31:0]  h_be    = head[`RCS_E_BE_LO +: 32];
  wire [3:0]   h_cnt   = head[`RCS_E_CNT_LO +: 4];
  wire         h_first = head[`RCS_E_FIRST];
  wire         h_last  = head[`RCS_E_LAST];
  wire         h_abort = head[`RCS_E_ABORT];
  wire         h_zl    = head[`RCS_E_ZLEN];
  wire [255:0] n_data  = nxt[`RCS_E_DATA_LO +: 256];
  wire [31:0]  n_be    = nxt[`RCS_E_BE_LO +: 32];
  wire [3:0]   n_cnt   = nxt[`RCS_E_CNT_LO +: 4];
  wire         n_first = nxt[`RCS_E_FIRST];
  wire         n_last  = nxt[`RCS_E_LAST];
  wire         n_abort = nxt[`RCS_E_ABORT];
  wire         n_zl    = nxt[`RCS_E_ZLEN];

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [7:0] pkt_cnt_reg;
  reg       second_reg;

  // The output register may take a new beat when empty or being accepted
  wire load = ~completion_out_valid_o | completion_out_ready_i;

  // A packet is only opened once it is wholly buffered (or the buffer is full),
  // so valid does not gap mid-packet; packets longer than the buffer rely on
  // the source keeping pace.
  wire may_start = (pkt_cnt_reg != 8'h00) | ~src_ready_o;
  assign take = load & head_valid & ((state_reg == ST_SEND) | may_start);

  // Straddle only a whole 3-4 dword packet into the upper half, after a
  // first packet that ends in the lower half without an abort
  assign merge = STR & take & h_last & (h_cnt <= `RCS_HALF_DW) & ~h_abort
                 & nxt_valid & n_first & n_last & ~n_abort
                 & ((n_cnt == 4'h3) | (n_cnt == 4'h4));

  // Next beat contents
  wire [31:0]  h_be_fix = be_fix(h_be, h_first, second_reg & ~h_first, h_zl);
  wire [31:0]  n_be_fix = be_fix(n_be, 1'b1, 1'b0, n_zl);
  wire [255:0] beat_data = merge ? {n_data[`RCS_HALF_W-1:0], h_data[`RCS_HALF_W-1:0]}
                                 : fit_data(h_data);
  wire [31:0]  beat_be = merge ? {n_be_fix[15:0], h_be_fix[15:0]} : h_be_fix;
  wire [31:0]  beat_par;
  wire [3:0]   n_end_off = n_cnt + 4'h3;
  wire [3:0]   h_end_off = h_cnt - 4'h1;

  rcs_parity #(
    .DW (DW)
  ) u_parity (
    .data_i   (beat_data),
    .parity_o (beat_par)
  );

  reg [`RCS_SB_W-1:0] sb_next;

  always @* begin
    sb_next = {`RCS_SB_W{1'b0}};
    sb_next[`RCS_SB_BE_LO +: 32] = beat_be;
    sb_next[`RCS_SB_SOF0] = h_first;
    if (STR) begin
      sb_next[`RCS_SB_SOF1] = merge;
      sb_next[`RCS_SB_EOF0_LO +: 4] = h_last ? {h_end_off[2:0], 1'b1} : 4'h0;
      sb_next[`RCS_SB_EOF1_LO +: 4] = merge ? {n_end_off[2:0], 1'b1} : 4'h0;
    end
    sb_next[`RCS_SB_ABORT] = h_abort & h_last;
    sb_next[`RCS_SB_PAR_LO +: 32] = beat_par;
  end

  always @* begin
    case (state_reg)
      ST_IDLE: begin
        state_next = (take & ~h_last) ? ST_SEND : ST_IDLE;
      end
      ST_SEND: begin
        state_next = (take & h_last) ? ST_IDLE : ST_SEND;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Whole packets are counted in on their last beat and out when it leaves
  wire pkt_in  = src_valid_i & src_ready_o & src_last_i;
  wire pkt_out = take & h_last;

  // Packets fully buffered; a merged beat retires two at once
  reg [7:0]           pkt_cnt_next;
  reg                 second_next;
  // Output register next values; everything holds while the consumer stalls
  reg [255:0]         out_data_next;
  reg [`RCS_SB_W-1:0] out_sb_next;
  reg                 out_last_next;
  reg [7:0]           out_keep_next;
  reg                 out_valid_next;

  always @* begin
    pkt_cnt_next = pkt_cnt_reg + {7'h00, pkt_in} - {7'h00, pkt_out} - {7'h00, merge};
    second_next  = second_reg;
    // Marks that the next head beat is the second beat of its packet
    if (take) begin
      second_next = h_first & ~h_last;
    end
  end

  always @* begin
    out_data_next  = completion_out_data_o;
    out_sb_next    = completion_out_sideband_o;
    out_last_next  = completion_out_last_beat_o;
    out_keep_next  = completion_out_dword_keep_o;
    out_valid_next = completion_out_valid_o;
    if (take) begin
      out_valid_next = 1'b1;
      out_data_next  = beat_data;
      out_sb_next    = sb_next;
      out_last_next  = STR ? 1'b0 : h_last;
      out_keep_next  = STR ? 8'hff : keep_of(h_cnt);
    end else if (load) begin
      out_valid_next = 1'b0;
    end
  end

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_reg                   <= ST_IDLE;
      pkt_cnt_reg                 <= 8'h00;
      second_reg                  <= 1'b0;
      completion_out_data_o       <= 256'h0;
      completion_out_sideband_o   <= {`RCS_SB_W{1'b0}};
      completion_out_last_beat_o  <= 1'b0;
      completion_out_dword_keep_o <= 8'h00;
      completion_out_valid_o      <= 1'b0;
    end else begin
      state_reg                   <= state_next;
      pkt_cnt_reg                 <= pkt_cnt_next;
      second_reg                  <= second_next;
      completion_out_valid_o      <= out_valid_next;
      completion_out_data_o       <= out_data_next;
      completion_out_sideband_o   <= out_sb_next;
      completion_out_last_beat_o  <= out_last_next;
      completion_out_dword_keep_o <= out_keep_next;
    end
  end

endmodule // rcs_completion_stream_out

`default_nettype wire

// file: design/rcs_fifo.v
// Synchronous FIFO with a peek at the second entry and a two-entry pop
`timescale 1ns/1ps
`default_nettype none

module rcs_fifo #(
  parameter integer W     = 296,
  parameter integer DEPTH = 8,
  parameter integer AW    = 3
) (
  // Clock and reset
  input  wire         clk_sys_i,
  input  wire         reset_i,
  // Fill side
  input  wire         in_valid_i,
  output wire         in_ready_o,
  input  wire [W-1:0] in_data_i,
  // Drain side
  output wire         out_valid_o,
  input  wire         out_ready_i,
  output wire [W-1:0] out_data_o,
  // Second entry peek, taken together with the head
  output wire         out2_valid_o,
  output wire [W-1:0] out2_data_o,
  input  wire         out2_take_i
);

  reg [W-1:0]  mem [0:DEPTH-1];
  reg [AW-1:0] rd_ptr_reg;
  reg [AW-1:0] wr_ptr_reg;
  reg [AW:0]   count_reg;
  reg          ready_reg;

  wire          push     = in_valid_i & ready_reg;
  wire          pop1     = out_ready_i & out_valid_o;
  wire          pop2     = pop1 & out2_take_i & out2_valid_o;
  wire [AW-1:0] rd_ptr_1 = rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
  wire [AW:0]   count_next = count_reg + {{AW{1'b0}}, push}
                             - {{AW{1'b0}}, pop1} - {{AW{1'b0}}, pop2};

  assign in_ready_o   = ready_reg;
  assign out_valid_o  = (count_reg != {(AW+1){1'b0}});
  assign out2_valid_o = (count_reg > {{AW{1'b0}}, 1'b1});
  assign out_data_o   = mem[rd_ptr_reg];
  assign out2_data_o  = mem[rd_ptr_1];

  always @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  // Ready is a flop so the fill side sees a clean level straight from a register
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      rd_ptr_reg <= {AW{1'b0}};
      wr_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
      ready_reg  <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop2) begin
        rd_ptr_reg <= rd_ptr_1 + {{(AW-1){1'b0}}, 1'b1};
      end else if (pop1) begin
        rd_ptr_reg <= rd_ptr_1;
      end
      count_reg <= count_next;
      ready_reg <= (count_next != DEPTH[AW:0]);
    end
  end

endmodule // rcs_fifo

`default_nettype wire

// file: design/rcs_parity.v
// Odd parity per data byte, lanes above the bus width forced low
`timescale 1ns/1ps
`default_nettype none

module rcs_parity #(
  parameter integer DW = 256
) (
  // Beat data
  input  wire [255:0] data_i,
  // Parity per byte
  output reg  [31:0]  parity_o
);

  integer i;

  always @* begin
    parity_o = 32'h0;
    for (i = 0; i < 32; i = i + 1) begin
      if (i < DW / 8) begin
        parity_o[i] = ~(^data_i[i*8 +: 8]);
      end
    end
  end

endmodule // rcs_parity

`default_nettype wire

// file: include/rcs_regs.vh
// Field positions, FIFO entry layout and sizes for the completion stream output
`ifndef RCS_REGS_VH
`define RCS_REGS_VH

// Sideband bundle layout
`define RCS_SB_W          75
`define RCS_SB_BE_LO      0
`define RCS_SB_BE_W       32
`define RCS_SB_SOF0       32
`define RCS_SB_SOF1       33
`define RCS_SB_EOF0_LO    34
`define RCS_SB_EOF1_LO    38
`define RCS_SB_ABORT      42
`define RCS_SB_PAR_LO     43

// Stream widths
`define RCS_DATA_W        256
`define RCS_KEEP_W        8
`define RCS_HALF_W        128
`define RCS_HALF_DW       4

// Descriptor length in dwords
`define RCS_DESC_DW       3

// FIFO entry layout
`define RCS_E_DATA_LO     0
`define RCS_E_BE_LO       256
`define RCS_E_CNT_LO      288
`define RCS_E_FIRST       292
`define RCS_E_LAST        293
`define RCS_E_ABORT       294
`define RCS_E_ZLEN        295
`define RCS_E_W           296

// Buffer size
`define RCS_FIFO_DEPTH    8
`define RCS_FIFO_AW       3

`endif

// file: test/rcs_stream_chk.sv
// Checker for the completion output stream ports
`timescale 1ns/1ps
`default_nettype none
module rcs_stream_chk #(
  parameter integer DW       = 256,
  parameter integer STRADDLE = 0
) (
  // Clock and reset
  input wire logic         clk_sys_i,
  input wire logic         reset_i,
  // Output stream
  input wire logic [255:0] completion_out_data_o,
  input wire logic [74:0]  completion_out_sideband_o,
  input wire logic         completion_out_last_beat_o,
  input wire logic [7:0]   completion_out_dword_keep_o,
  input wire logic         completion_out_valid_o,
  input wire logic         completion_out_ready_i
);
  localparam logic [7:0] FULL = 8'((1 << (DW / 32)) - 1);
  // Straddling only takes effect on the widest bus
  localparam bit STR = (STRADDLE != 0) && (DW == 256);
  function automatic bit contig(input logic [31:0] x);
    return ((x + (x & -x)) & x) == 32'h0;
  endfunction
  wire         v  = completion_out_valid_o;
  wire         r  = completion_out_ready_i;
  wire         l  = completion_out_last_beat_o;
  wire [7:0]   k  = completion_out_dword_keep_o;
  wire [74:0]  sb = completion_out_sideband_o;
  wire [31:0]  be = sb[31:0];
  logic        in_pkt_reg;
  logic [31:0] par;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // Tracks whether the next shown beat continues a packet rather than starting one
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) in_pkt_reg <= 1'b0;
    else if (v && r) in_pkt_reg <= !l;
  end
  always_comb begin
    for (int i = 0; i < 32; i++) par[i] = (i < DW / 8) ? ~^completion_out_data_o[8*i+:8] : 1'b0;
  end
  sequence stall_s;
    v && !r;
  endsequence
  a_stall_hold: assert property (stall_s |=> v && $stable(sb) && $stable(k)
    && $stable(completion_out_data_o)) else $error("stalled beat changed");
  a_pkt_valid: assert property (!STR && v && r && !l |=> v)
    else $error("valid dropped inside packet");
  a_keep_contig: assert property (v |-> k != 8'h00 && ((k + 8'h01) & k) == 8'h00)
    else $error("keep not contiguous");
  a_keep_full: assert property (v && !l |-> k == FULL) else $error("keep short mid packet");
  a_keep_width: assert property ((k & ~FULL) == 8'h00) else $error("keep above width");
  a_start_mark: assert property (!STR && v |-> sb[32] == !in_pkt_reg)
    else $error("start flag wrong");
  a_start1_low: assert property (!STR |-> !sb[33]) else $error("second start set");
  a_last_low: assert property (STR |-> !l) else $error("last set in straddle");
  a_abort_last: assert property (v && sb[42] |-> (STR ? sb[34] : l))
    else $error("abort not in last beat");
  a_start1_end0: assert property (v && sb[33] |-> sb[34])
    else $error("second start without first end");
  a_end1_imply: assert property (v && sb[38] |-> sb[34] && sb[33] && sb[41:40] == 2'b11)
    else $error("second end field wrong");
  a_end_unused: assert property (!STR |-> sb[41:34] == 8'h00)
    else $error("end fields set without straddling");
  a_parity_ok: assert property (v |-> sb[74:43] == par) else $error("parity wrong");
  a_be_contig: assert property (v |-> ((STR && sb[33]) ?
    (contig(be & 32'h0000_ffff) && contig(be & 32'hffff_0000)) : contig(be)))
    else $error("byte valid not contiguous");
  a_be_desc: assert property (v && sb[32] |-> sb[11:0] == 12'h000
    && (!sb[33] || sb[27:16] == 12'h000)) else $error("byte valid on descriptor");
  a_data_width: assert property ((completion_out_data_o >> DW) == 256'h0)
    else $error("data above width");
endmodule // rcs_stream_chk
bind rcs_completion_stream_out rcs_stream_chk #(.DW(DW), .STRADDLE(STRADDLE)) i_chk (
  .clk_sys_i, .reset_i, .completion_out_data_o, .completion_out_sideband_o,
  .completion_out_last_beat_o, .completion_out_dword_keep_o, .completion_out_valid_o,
  .completion_out_ready_i
);
`default_nettype wire

// file: test/rcs_user_sink.sv
// User logic model that consumes completion packets
`timescale 1ns/1ps
`default_nettype none
module rcs_user_sink (
  // Clock and reset
  input wire logic  clk_sys_i,
  input wire logic  reset_i,
  // Stream
  input wire logic  valid_i,
  input wire logic  last_i,
  input wire logic  abort_i,
  output logic      ready_o,
  // Pacing and count
  input wire logic  stall_i,
  input wire logic  slow_i,
  output logic [7:0] pkts_o
);
  logic tick_reg;
  always @(negedge clk_sys_i) begin
    tick_reg <= reset_i ? 1'b0 : !tick_reg;
  end
  assign ready_o = !stall_i && (!slow_i || tick_reg);
  // Only beats with both valid and ready count; aborted packets are dropped
  always @(posedge clk_sys_i) begin
    if (reset_i) pkts_o <= 8'h00;
    else if (valid_i && ready_o && last_i && !abort_i) pkts_o <= pkts_o + 8'h01;
  end
endmodule // rcs_user_sink
`default_nettype wire

// file: test/test_requester_completion_stream_out.sv
// Testbench for the completion output stream
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module test_requester_completion_stream_out;
  logic         clk_sys_i, reset_i, src_valid_i, src_ready_o, src_first_i, src_last_i;
  logic         src_abort_i, src_zero_len_i, last, valid, ready, stall, slow, last_s, valid_s;
  logic [255:0] src_data_i, data, data_s, pair;
  logic [3:0]   src_dword_count_i;
  logic [31:0]  src_byte_en_i;
  logic [74:0]  sb, sb_s;
  logic [7:0]   keep, pkts, keep_s;
  logic [339:0] q[$], qs[$];
  int           mismatches, checked, n;
  rcs_completion_stream_out #(.DW(256), .STRADDLE(0)) i_dut (
    .clk_sys_i, .reset_i, .src_valid_i, .src_ready_o, .src_data_i, .src_dword_count_i,
    .src_byte_en_i, .src_first_i, .src_last_i, .src_abort_i, .src_zero_len_i,
    .completion_out_data_o(data), .completion_out_sideband_o(sb),
    .completion_out_last_beat_o(last), .completion_out_dword_keep_o(keep),
    .completion_out_valid_o(valid), .completion_out_ready_i(ready)
  );
  rcs_user_sink i_sink (
    .clk_sys_i, .reset_i, .valid_i(valid), .last_i(last), .abort_i(sb[42]),
    .ready_o(ready), .stall_i(stall), .slow_i(slow), .pkts_o(pkts)
  );
  // Straddling twin fed the beats that the main block accepts, drained unless stalled
  rcs_completion_stream_out #(.DW(256), .STRADDLE(1)) i_dut_str (
    .clk_sys_i, .reset_i, .src_valid_i(src_valid_i && src_ready_o), .src_ready_o(),
    .src_data_i, .src_dword_count_i, .src_byte_en_i, .src_first_i, .src_last_i,
    .src_abort_i, .src_zero_len_i, .completion_out_data_o(data_s),
    .completion_out_sideband_o(sb_s), .completion_out_last_beat_o(last_s),
    .completion_out_dword_keep_o(keep_s), .completion_out_valid_o(valid_s),
    .completion_out_ready_i(!stall)
  );
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = !clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    if (valid && ready) q.push_back({last, keep, sb, data});
    if (valid_s && !stall) qs.push_back({last_s, keep_s, sb_s, data_s});
  end
  function automatic [255:0] mk(input [7:0] s, input [3:0] c);
    for (int i = 0; i < 8; i++) mk[32*i+:32] = (i < c) ? {4{s + 8'(i)}} : 32'h0;
  endfunction
  function automatic [31:0] par(input [255:0] d);
    for (int i = 0; i < 32; i++) par[i] = ~^d[8*i+:8];
  endfunction
  // Called at a falling edge; leaves the beat offered until the next call
  task push(input [7:0] s, input [3:0] c, input f, input l, input ab, input zl);
    int w;
    w = 0;
    src_valid_i = 1'b1;
    src_data_i = mk(s, c);
    src_dword_count_i = c;
    src_byte_en_i = zl ? 32'h0 : 32'((64'h1 << (4 * c)) - 64'h1);
    {src_first_i, src_last_i, src_abort_i, src_zero_len_i} = {f, l, ab, zl};
    while (src_ready_o !== 1'b1 && w < 200) begin @(negedge clk_sys_i); w++; end
    if (w == 200) mismatches++;
    @(negedge clk_sys_i);
  endtask
  task expect_beat(input [255:0] d, input [31:0] be, input st, input ls, input ab,
                   input [7:0] kp);
    logic [339:0] b;
    int w;
    w = 0;
    while (q.size() == 0 && w < 300) begin @(negedge clk_sys_i); w++; end
    `CHK("beat", 1'b1, q.size() != 0)
    if (q.size() != 0) begin
      b = q.pop_front();
      `CHK("data", d, b[255:0])
      `CHK("sideband", {par(d), ab, 1'b0, st, be}, {b[330:298], b[289:256]})
      `CHK("last_keep", {ls, kp}, b[339:331])
    end
  endtask
  // fl holds end1, end0, start1, start0 as they sit in the sideband
  task expect_str(input [255:0] d, input [31:0] be, input [9:0] fl, input ab);
    logic [339:0] b;
    `CHK("str_beat", 1'b1, qs.size() != 0)
    if (qs.size() != 0) begin
      b = qs.pop_front();
      `CHK("str_data", d, b[255:0])
      `CHK("str_sideband", {par(d), ab, fl, be}, b[330:256])
      `CHK("str_last_keep", 9'h0ff, b[339:331])
    end
  endtask
  task finish_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    finish_test;
  end
  initial begin
    {reset_i, src_valid_i, src_first_i, src_last_i, src_abort_i, src_zero_len_i} = 6'h20;
    {src_data_i, src_dword_count_i, src_byte_en_i, stall, slow} = '0;
    repeat (16) @(negedge clk_sys_i);
    reset_i = 1'b0;
    @(negedge clk_sys_i);
    `CHK("ready_after_reset", 2'h2, {src_ready_o, valid})
    push(8'h10, 4'h5, 1'b1, 1'b1, 1'b0, 1'b0);
    src_valid_i = 1'b0;
    expect_beat(mk(8'h10, 4'h5), 32'h000ff000, 1'b1, 1'b1, 1'b0, 8'h1f);
    stall = 1'b1;
    push(8'h20, 4'h8, 1'b1, 1'b0, 1'b0, 1'b0);
    push(8'h30, 4'h2, 1'b0, 1'b1, 1'b1, 1'b0);
    src_valid_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    `CHK("stalled", 2'h2, {valid, q.size() != 0})
    stall = 1'b0;
    expect_beat(mk(8'h20, 4'h8), 32'hfffff000, 1'b1, 1'b0, 1'b0, 8'hff);
    expect_beat(mk(8'h30, 4'h2), 32'h000000ff, 1'b0, 1'b1, 1'b1, 8'h03);
    slow = 1'b1;
    push(8'h50, 4'h3, 1'b1, 1'b1, 1'b0, 1'b1);
    src_valid_i = 1'b0;
    expect_beat(mk(8'h50, 4'h3), 32'h00001000, 1'b1, 1'b1, 1'b0, 8'h07);
    // Fill the buffer behind a stalled consumer, then drain it slowly
    stall = 1'b1;
    n = 0;
    while (src_ready_o === 1'b1 && n < 12) begin
      push(8'h60 + 8'(n), 4'h4, 1'b1, 1'b1, 1'b0, 1'b0);
      n++;
    end
    src_valid_i = 1'b0;
    `CHK("fill", 2'h1, {src_ready_o, n >= 8 && n <= 9})
    stall = 1'b0;
    for (int i = 0; i < n; i++)
      expect_beat(mk(8'h60 + 8'(i), 4'h4), 32'h0000f000, 1'b1, 1'b1, 1'b0, 8'h0f);
    repeat (4) @(negedge clk_sys_i);
    `CHK("drained", 2'h2, {src_ready_o, valid})
    `CHK("packets", 8'(n + 2), pkts)
    // Straddling twin: singles through the first fill packet, then the rest paired two to a beat, any odd one left alone
    expect_str(mk(8'h10, 4'h5), 32'h000ff000, 10'h025, 1'b0);
    expect_str(mk(8'h20, 4'h8), 32'hfffff000, 10'h001, 1'b0);
    expect_str(mk(8'h30, 4'h2), 32'h000000ff, 10'h00c, 1'b1);
    expect_str(mk(8'h50, 4'h3), 32'h00001000, 10'h015, 1'b0);
    expect_str(mk(8'h60, 4'h4), 32'h0000f000, 10'h01d, 1'b0);
    for (int i = 1; i < n; i += 2) begin
      pair = (mk(8'h61 + 8'(i), 4'h4) << 128) | mk(8'h60 + 8'(i), 4'h4);
      if (i + 1 < n) expect_str(pair, 32'hf000f000, 10'h3df, 1'b0);
      else expect_str(mk(8'h60 + 8'(i), 4'h4), 32'h0000f000, 10'h01d, 1'b0);
    end
    `CHK("str_extra", 1'b0, qs.size() != 0)
    finish_test;
  end
endmodule // test_requester_completion_stream_out
`default_nettype wire
